// ### actl_pkg.sv
// package for the graphics port command and translation control block
// assumes a 32-bit classic wishbone register bus and one 100 MHz clock
package actl_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_LINK_STATUS = 8'hA4;
  localparam logic [7:0] ADDR_LINK_COMMAND = 8'hA8;
  localparam logic [7:0] ADDR_LINK_CONTROL = 8'hB0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RATE_LSB = 0;
  localparam int RATE_QUAD_BIT = 2;
  localparam int POSTED_WRITE_BIT = 4;
  localparam int ABOVE_BOUNDARY_BIT = 5;
  localparam int SIDEBAND_CAP_BIT = 9;
  localparam int QUEUE_DEPTH_LSB = 24;
  localparam int QUAD_MASK_BIT = 0;
  localparam int CACHE_ENABLE_BIT = 7;

  // ---------------------------------------------------------------
  // reset and hardwired values
  // ---------------------------------------------------------------
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [2:0] COMMAND_RATE_RESET = 3'h0;
  localparam logic [2:0] RATE_CAP_RESET = 3'h7;
  localparam logic [7:0] QUEUE_DEPTH_VALUE = 8'h1F;
  localparam logic [2:0] RATE_ONE = 3'h1;
  localparam logic [2:0] RATE_TWO = 3'h2;
  localparam logic [2:0] RATE_FOUR = 3'h4;

  typedef enum logic [1:0] {
    RATE_NONE = 2'b00,
    RATE_1X = 2'b01,
    RATE_2X = 2'b10,
    RATE_4X = 2'b11
  } actl_rate_e;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_FETCH = 2'b01,
    LK_DONE = 2'b10
  } actl_lookup_e;

endpackage

// ### actl_command_tlb_control.sv
// command, control and status registers of the graphics port target, plus the
// aperture translation cache they steer
// assumes a classic wishbone master, a memory port that fetches table entries,
// and a write buffer elsewhere that flushes on a one-cycle pulse
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns

// Contract
// - above-boundary bit reads zero; addresses beyond 4 GB are refused.
// - rate select decodes one-hot: bit0 1X, bit1 2X, bit2 4X.
// - with quad rate mask set, rate bit 2 ignores writes and keeps its value.
// - the selected rate drives both the data bus and the sideband bus.
// - control bit 7 set: translation cache serves lookups normally.
// - control bit 7 clear: all cache valid bits are cleared.
// - cache disabled: every aperture lookup not refused as above-boundary fetches its entry from memory.
// - cache disabled: fetched entries are not stored.
// - cache enabled: invalid fetched entries are still cached, replacing LRU.
// - any write of the enable bit flushes the graphics write buffer.
// - enable bit may change during a lookup without harming it.
// - quad rate mask set: status rate bit 2 reads zero.
// - status rate capability resets to 111.
module actl_command_tlb_control
  import actl_pkg::*;
#(
  parameter int ENTRIES = 4,
  parameter int PAGE_W = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  output logic [2:0] adBusRate,
  output logic [2:0] sidebandRate,
  output actl_rate_e linkRate,
  output logic graphicsWriteBufferFlush,
  input wire logic lookupValid,
  input wire logic [PAGE_W-1:0] lookupPage,
  input wire logic lookupAboveBoundary,
  output logic lookupReady,
  output logic lookupDone,
  output logic lookupRefused,
  output logic [31:0] lookupEntry,
  output logic fetchReq,
  output logic [PAGE_W-1:0] fetchPage,
  input wire logic fetchAck,
  input wire logic [31:0] fetchData
);

  localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  // elaboration checks: the age ranking and index decode assume a power of two
  if (ENTRIES < 2 || ENTRIES > 64 || (ENTRIES & (ENTRIES - 1)) != 0) begin : gBadEntries
    $error("ENTRIES must be a power of two from 2 to 64");
  end
  if (PAGE_W < 1 || PAGE_W > 32) begin : gBadPageWidth
    $error("PAGE_W must be 1 to 32");
  end

  // no bit or several bits set decode as no rate; software must not leave it so
  function automatic actl_rate_e decodeRate(input logic [2:0] sel);
    case (sel)
      RATE_ONE: decodeRate = RATE_1X;
      RATE_TWO: decodeRate = RATE_2X;
      RATE_FOUR: decodeRate = RATE_4X;
      default: decodeRate = RATE_NONE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic [2:0] rateSelect;
  logic postedBurstWriteEnable;
  logic quadRateMask;
  logic translationCacheEnable;
  logic [2:0] rateCapability;

  // every address is acknowledged, mapped or not, so a stray access never hangs the bus
  wire busReq = wbCyc & wbStb;
  wire hitStatus = wbAdr == ADDR_LINK_STATUS;
  wire hitCommand = wbAdr == ADDR_LINK_COMMAND;
  wire hitControl = wbAdr == ADDR_LINK_CONTROL;
  // a write lands on the edge where the master sees ack
  wire doWrite = busReq & wbWe & wbAck & wbSel[0];
  wire writeCommand = doWrite & hitCommand;
  wire writeControl = doWrite & hitControl;

  // masking only hides the capability; the stored value is untouched
  wire [2:0] shownCapability = {rateCapability[2] & ~quadRateMask, rateCapability[1:0]};

  wire [31:0] statusWord = {QUEUE_DEPTH_VALUE, 14'h0000, 1'b1, 3'h0,
                            1'b0, 1'b0, 1'b0, shownCapability};
  wire [31:0] commandWord = {26'h0000000, 1'b0, postedBurstWriteEnable, 1'b0,
                             rateSelect};
  wire [31:0] controlWord = {24'h000000, translationCacheEnable, 6'h00,
                             quadRateMask};
  wire [31:0] readMux = hitStatus ? statusWord :
                        hitCommand ? commandWord :
                        hitControl ? controlWord : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (reset) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck <= busReq & ~wbAck;
      wbDatOut <= readMux;
    end
  end

  // ---------------------------------------------------------------
  // command and control registers
  // ---------------------------------------------------------------
  // rate bit 2 freezes while the quad rate mask is set
  wire [2:0] next_rateSelect = {quadRateMask ? rateSelect[2] : wbDatIn[2],
                                wbDatIn[1:0]};

  always_ff @(posedge clk) begin
    if (reset) begin
      rateSelect <= COMMAND_RATE_RESET;
      postedBurstWriteEnable <= 1'b0;
      quadRateMask <= CONTROL_RESET[QUAD_MASK_BIT];
      translationCacheEnable <= CONTROL_RESET[CACHE_ENABLE_BIT];
      rateCapability <= RATE_CAP_RESET;
    end else begin
      if (writeCommand) begin
        rateSelect <= next_rateSelect;
        postedBurstWriteEnable <= wbDatIn[POSTED_WRITE_BIT];
      end
      if (writeControl) begin
        quadRateMask <= wbDatIn[QUAD_MASK_BIT];
        translationCacheEnable <= wbDatIn[CACHE_ENABLE_BIT];
      end
    end
  end

  // one rate field governs both the data bus and the sideband bus
  assign adBusRate = rateSelect;
  assign sidebandRate = rateSelect;
  assign linkRate = decodeRate(rateSelect);

  // the flush pulse follows every write of the enable bit, set or clear
  always_ff @(posedge clk) begin
    if (reset) begin
      graphicsWriteBufferFlush <= 1'b0;
    end else begin
      graphicsWriteBufferFlush <= writeControl;
    end
  end

  // ---------------------------------------------------------------
  // translation cache
  // ---------------------------------------------------------------
  logic [ENTRIES-1:0] entryValid;
  logic [PAGE_W-1:0] entryPage [ENTRIES];
  logic [31:0] entryData [ENTRIES];
  logic [IDX_W-1:0] entryAge [ENTRIES];
  logic [ENTRIES-1:0] hitVec;
  logic [ENTRIES-1:0] oldestVec;
  logic [IDX_W-1:0] hitIdx;
  logic [IDX_W-1:0] victimIdx;
  logic [31:0] hitData;

  actl_lookup_e state;
  actl_lookup_e next_state;
  logic [PAGE_W-1:0] pendPage;

  wire takeLookup = lookupValid & lookupReady;
  wire cacheHit = translationCacheEnable & (|hitVec);
  wire fetchDone = state == LK_FETCH && fetchAck;
  // enable sampled when the entry returns, so a mid-lookup change is safe
  wire storeEntry = fetchDone & translationCacheEnable;
  wire touch = storeEntry | (takeLookup & ~lookupAboveBoundary & cacheHit);
  wire [IDX_W-1:0] touchIdx = storeEntry ? victimIdx : hitIdx;

  always_comb begin
    hitIdx = '0;
    victimIdx = '0;
    hitData = 32'h0000_0000;
    for (int i = 0; i < ENTRIES; i++) begin
      if (hitVec[i]) begin
        hitIdx = IDX_W'(i);
        hitData = entryData[i];
      end
      if (oldestVec[i]) begin
        victimIdx = IDX_W'(i);
      end
    end
  end

  // ages form a ranking 0..ENTRIES-1; the entry of highest age is the victim
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++) begin : gEntry
      assign hitVec[g] = entryValid[g] && entryPage[g] == lookupPage;
      assign oldestVec[g] = entryAge[g] == IDX_W'(ENTRIES - 1);

      always_ff @(posedge clk) begin
        if (reset) begin
          entryValid[g] <= 1'b0;
          entryPage[g] <= '0;
          entryData[g] <= 32'h0000_0000;
          entryAge[g] <= IDX_W'(g);
        end else begin
          if (!translationCacheEnable) begin
            entryValid[g] <= 1'b0;
          end else if (storeEntry && victimIdx == IDX_W'(g)) begin
            // stored whatever its own valid flag says
            entryValid[g] <= 1'b1;
            entryPage[g] <= pendPage;
            entryData[g] <= fetchData;
          end
          if (touch) begin
            if (touchIdx == IDX_W'(g)) begin
              entryAge[g] <= '0;
            end else if (entryAge[g] < entryAge[touchIdx]) begin
              entryAge[g] <= entryAge[g] + IDX_W'(1);
            end
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // lookup sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      LK_IDLE: begin
        if (takeLookup && !lookupAboveBoundary && !cacheHit) begin
          next_state = LK_FETCH;
        end else if (takeLookup) begin
          next_state = LK_DONE;
        end
      end
      LK_FETCH: begin
        if (fetchAck) begin
          next_state = LK_DONE;
        end
      end
      LK_DONE: next_state = LK_IDLE;
      default: next_state = LK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= LK_IDLE;
      pendPage <= '0;
      lookupDone <= 1'b0;
      lookupRefused <= 1'b0;
      lookupEntry <= 32'h0000_0000;
    end else begin
      state <= next_state;
      lookupDone <= (takeLookup & (lookupAboveBoundary | cacheHit)) | fetchDone;
      if (takeLookup) begin
        pendPage <= lookupPage;
        lookupRefused <= lookupAboveBoundary;
        lookupEntry <= lookupAboveBoundary ? 32'h0000_0000 : hitData;
      end else if (fetchDone) begin
        lookupEntry <= fetchData;
      end
    end
  end

  assign lookupReady = state == LK_IDLE;
  assign fetchReq = state == LK_FETCH;
  assign fetchPage = pendPage;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_quad_bit_frozen: assert property (
    writeCommand && quadRateMask |=> rateSelect[2] == $past(rateSelect[2]))
    else $error("rate bit 2 changed under quad rate mask");
  a_quad_mask_read: assert property (
    busReq && !wbAck && !wbWe && hitStatus && quadRateMask |=> wbAck && wbDatOut[2] == 1'b0)
    else $error("status rate bit 2 not masked");
  a_above_reads_zero: assert property (
    busReq && !wbAck && hitCommand |=> wbDatOut[ABOVE_BOUNDARY_BIT] == 1'b0)
    else $error("above-boundary bit read nonzero");
  a_above_refused: assert property (
    takeLookup && lookupAboveBoundary |=> lookupDone && lookupRefused && !fetchReq)
    else $error("above-boundary lookup not refused");
  a_rate_both_buses: assert property (
    adBusRate == sidebandRate && adBusRate == rateSelect)
    else $error("buses run at different rates");
  a_rate_decode: assert property (
    rateSelect == RATE_FOUR |-> linkRate == RATE_4X)
    else $error("rate bit 2 not decoded as 4X");
  a_disable_flush: assert property (
    !translationCacheEnable |=> entryValid == '0)
    else $error("cache not flushed while disabled");
  a_bypass_fetch: assert property (
    takeLookup && !lookupAboveBoundary && !translationCacheEnable |=> fetchReq)
    else $error("disabled cache did not fetch");
  a_no_store_off: assert property (
    fetchDone && !translationCacheEnable |=> entryValid == '0)
    else $error("entry stored while disabled");
  a_invalid_cached: assert property (
    fetchDone && translationCacheEnable && !fetchData[0] |=> entryValid[$past(victimIdx)])
    else $error("invalid entry not cached");
  a_flush_pulse: assert property (
    writeControl |=> graphicsWriteBufferFlush ##1 !graphicsWriteBufferFlush || writeControl)
    else $error("write buffer flush not pulsed");
  a_enable_midway: assert property (
    fetchReq && fetchAck |=> lookupDone && lookupEntry == $past(fetchData))
    else $error("lookup corrupted by enable change");
  a_hit_no_fetch: assert property (
    takeLookup && !lookupAboveBoundary && cacheHit |=> lookupDone && !fetchReq)
    else $error("cache hit still went to memory");
  a_flush_after_write: assert property (
    graphicsWriteBufferFlush |-> $past(writeControl))
    else $error("write buffer flushed without a control write");
  a_cap_reset: assert property (
    rateCapability == RATE_CAP_RESET)
    else $error("rate capability lost its reset value");
  a_reserved_zero: assert property (
    wbAck && hitControl |-> wbDatOut[6:1] == 6'h00 && wbDatOut[31:8] == 24'h000000)
    else $error("reserved control bits read nonzero");

  c_hit: cover property (takeLookup && cacheHit);
  c_fetch_store: cover property (storeEntry);
  c_mask_write: cover property (writeCommand && quadRateMask);
  c_enable_during_fetch: cover property (writeControl && fetchReq);

endmodule

// ### actl_mem_model.sv
// memory side model that answers translation table fetches
// assumes the fetch port contract: fetchReq level, fetchAck one-cycle pulse
`timescale 1ns/1ns
module actl_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic fetchReq,
  input wire logic [19:0] fetchPage,
  input wire logic [3:0] delay,
  input wire logic entryValid,
  output logic fetchAck,
  output logic [31:0] fetchData,
  output logic [7:0] fetchCount
);
  logic armed;
  logic [3:0] waitCnt;
  initial begin
    fetchAck = 1'b0;
    fetchData = 32'h0;
    fetchCount = 8'h0;
    armed = 1'b0;
    waitCnt = 4'h0;
  end
  // data bus wanders between answers so a stale value never passes
  always @(posedge clk) begin
    fetchAck <= 1'b0;
    fetchData <= ~fetchData;
    if (reset) begin
      armed <= 1'b0;
    end else if (fetchReq && !fetchAck && !armed) begin
      armed <= 1'b1;
      waitCnt <= delay;
      fetchCount <= fetchCount + 8'h1;
    end else if (armed && waitCnt == 4'h0) begin
      fetchAck <= 1'b1;
      fetchData <= {fetchPage, 11'h0, entryValid};
      armed <= 1'b0;
    end else if (armed) begin
      waitCnt <= waitCnt - 4'h1;
    end
  end
endmodule

// ### actl_command_tlb_control_tb.sv
// self-checking bench for the command, control and translation cache block
// assumes the wishbone and lookup timing of the designer's contract
`timescale 1ns/1ns
module actl_command_tlb_control_tb;
  import actl_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h0;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatIn = 32'h0, wbDatOut, q, lkEntry, fetchData;
  logic wbAck, flush, lookupReady, lookupDone, lookupRefused, fetchReq, fetchAck, lkRef;
  logic [2:0] adBusRate, sidebandRate;
  actl_rate_e linkRate;
  logic lookupValid = 1'b0, lookupAboveBoundary = 1'b0, entryValid = 1'b1;
  logic [19:0] lookupPage = 20'h0, fetchPage;
  logic [3:0] delay = 4'h0;
  logic [7:0] fetchCount;
  int failures = 0, cmpCount = 0, flushCount = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (flush === 1'b1) flushCount++;
  actl_command_tlb_control DUT (.clk(clk), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .adBusRate(adBusRate), .sidebandRate(sidebandRate), .linkRate(linkRate),
    .graphicsWriteBufferFlush(flush), .lookupValid(lookupValid), .lookupPage(lookupPage),
    .lookupAboveBoundary(lookupAboveBoundary), .lookupReady(lookupReady),
    .lookupDone(lookupDone), .lookupRefused(lookupRefused), .lookupEntry(lkEntry),
    .fetchReq(fetchReq), .fetchPage(fetchPage), .fetchAck(fetchAck), .fetchData(fetchData));
  actl_mem_model MEM (.clk(clk), .reset(reset), .fetchReq(fetchReq), .fetchPage(fetchPage),
    .delay(delay), .entryValid(entryValid), .fetchAck(fetchAck), .fetchData(fetchData),
    .fetchCount(fetchCount));
  // -------------------------------------------------
  // tasks
  // -------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDatIn <= d; wbSel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    q = wbDatOut;
    wbCyc <= 1'b0; wbStb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(q, e);
  endtask
  task automatic look(input logic [19:0] p, input logic hi);
    int n;
    n = 0;
    @(posedge clk);
    lookupValid <= 1'b1; lookupPage <= p; lookupAboveBoundary <= hi;
    do begin
      @(posedge clk);
      n++;
    end while (lookupReady !== 1'b1 && n < 50);
    lookupValid <= 1'b0;
    while (lookupDone !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) failures++;
    lkRef = lookupRefused;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // -------------------------------------------------
  // tests
  // -------------------------------------------------
  initial begin
    #100000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_LINK_STATUS, 32'h1F00_0207);
    rd(ADDR_LINK_COMMAND, 32'h0);
    rd(ADDR_LINK_CONTROL, 32'h0);
    rd(8'hB4, 32'h0);
    chk({30'h0, linkRate}, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_LINK_COMMAND, 32'h1 << i);
      // the rate field updates on the ack edge itself; look one edge later
      @(posedge clk);
      chk({29'h0, adBusRate}, 32'h1 << i);
      chk({29'h0, sidebandRate}, 32'h1 << i);
      chk({30'h0, linkRate}, i + 1);
    end
    wr(ADDR_LINK_COMMAND, 32'hFFFF_FFE4);
    rd(ADDR_LINK_COMMAND, 32'h4);
    xfer(1'b1, ADDR_LINK_COMMAND, 32'h1, 4'hE);
    rd(ADDR_LINK_COMMAND, 32'h4);
    $display("rate select done");
    wr(ADDR_LINK_CONTROL, 32'hFFFF_FFFF);
    rd(ADDR_LINK_CONTROL, 32'h81);
    rd(ADDR_LINK_STATUS, 32'h1F00_0203);
    wr(ADDR_LINK_COMMAND, 32'h1);
    rd(ADDR_LINK_COMMAND, 32'h5);
    wr(ADDR_LINK_CONTROL, 32'h0);
    wr(ADDR_LINK_COMMAND, 32'h1);
    rd(ADDR_LINK_COMMAND, 32'h1);
    repeat (2) @(posedge clk);
    chk(flushCount, 2);
    $display("override done");
    look(20'h5, 1'b0);
    look(20'h5, 1'b0);
    chk(fetchCount, 2);
    chk(lkEntry, {20'h5, 12'h1});
    wr(ADDR_LINK_CONTROL, 32'h80);
    entryValid <= 1'b0;
    delay <= 4'h3;
    look(20'h7, 1'b0);
    look(20'h7, 1'b0);
    chk(fetchCount, 3);
    chk(lkEntry, {20'h7, 12'h0});
    wr(ADDR_LINK_CONTROL, 32'h0);
    look(20'h7, 1'b0);
    chk(fetchCount, 4);
    look(20'h9, 1'b1);
    chk(lkRef, 1'b1);
    chk(fetchCount, 4);
    entryValid <= 1'b1;
    fork
      look(20'hA, 1'b0);
      wr(ADDR_LINK_CONTROL, 32'h80);
    join
    chk(lkEntry, {20'hA, 12'h1});
    chk(lkRef, 1'b0);
    $display("translation cache done");
    stop_test;
  end
endmodule
